// ===== core/xto_clock_consts.svh
// Constants of the crystal clock divider and gating block
`ifndef XTO_CLOCK_CONSTS_SVH
`define XTO_CLOCK_CONSTS_SVH
`define XTO_PER_CLK      2
`define CLKOUT_DIV       3
`define DCLK_DIV         16
`define CLKOUT_HALF      3'h3
`define CLKOUT_LAST      3'h5
`define DCLK_LAST        5'h1F
`define ADR_CTRL         8'h00
`define ADR_SYNTH_FREQUENCY_WORD_LO      8'h04
`define ADR_SYNTH_FREQUENCY_WORD_HI      8'h08
`define ADR_LIMIT        8'h0C
`define ADR_STATUS       8'h10
`define CTRL_PERMIT      0
`define CTRL_REQUEST     1
`define CTRL_BAND        2
`define CTRL_RMODE       3
`define CTRL_BR_LO       4
`define CTRL_BR_HI       5
`define ST_OSC_OK        0
`define ST_SWITCH_ON     1
`define ST_BUTTON        2
`define ST_CLK_RUN       3
`define ST_SUPPLY_OK     4
`define RST_PERMIT       1'b1
`define RST_REQUEST      1'b1
`define RST_SYNTH_FREQUENCY_WORD_LO      8'hFF
`define RST_SYNTH_FREQUENCY_WORD_HI      5'h0F
`define RST_LIMIT        8'h01
`define SYNTH_FREQUENCY_WORD_MODE0_BASE  2'h3
`define SYNTH_FREQUENCY_WORD_MODE0_MIN   13'h0C00
`define SYNTH_FREQUENCY_WORD_MODE0_MAX   13'h0FFF
`define BR_SHIFT_MAX     2'h3
`endif

// ===== core/xto_clock_pkg.sv
// Types of the crystal clock divider and gating block
package xto_clock_pkg;
  typedef logic [12:0] synth_frequency_word_word_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        permit;
    logic        request;
    logic        band;
    logic        rmode;
    logic [1:0]  bit_rate_range_select;
    logic [7:0]  synth_frequency_word_lo;
    logic [4:0]  synth_frequency_word_hi;
    logic [7:0]  xlim;
    logic        sw_flag;
    logic        btn_flag;
    logic        wake;
    logic        run;
    logic        clk_o;
    logic [2:0]  div_cnt;
    logic [4:0]  dclk_cnt;
    logic        dclk_tick;
    logic [10:0] bit_cnt;
    logic        bit_tick;
    logic        irq;
    logic        cap_off;
    logic        amp_s1;
    logic        amp_s2;
    logic        sup_s1;
    logic        sup_s2;
    logic        sw_s1;
    logic        sw_s2;
    logic        sw_s3;
    logic        btn_s1;
    logic        btn_s2;
    logic        btn_s3;
  } clk_state_s;
endpackage

// ===== core/xto_clock_gen.sv
// Crystal clock divider, controller clock gating and bit timing
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "xto_clock_consts.svh"
module xto_clock_gen (
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic                     wb_cyc_in,
  input  wire logic                     wb_stb_in,
  input  wire logic                     wb_we_in,
  input  wire logic [7:0]               wb_adr_in,
  input  wire logic [3:0]               wb_sel_in,
  input  wire logic [31:0]              wb_dat_in,
  output      logic [31:0]              wb_dat_out,
  output      logic                     wb_ack_out,
  input  wire logic                     amplitude_ok_in,
  input  wire logic                     supply_ok_in,
  input  wire logic                     switch_on_input_in,
  input  wire logic                     push_button_wake_pin_n_in,
  input  wire logic                     bit_check_ok_in,
  input  wire logic                     low_power_mode_in,
  output      logic                     mcu_clk_out,
  output      logic                     oscillator_ok_flag_out,
  output      logic                     switch_on_flag_out,
  output      logic                     switch_on_irq_out,
  output      logic                     dclk_tick_out,
  output      logic                     bit_tick_out,
  output      logic                     cap_partial_off_out,
  output      logic                     band_select_bit_out,
  output      xto_clock_pkg::synth_frequency_word_word_t synth_frequency_word_out
);
  import xto_clock_pkg::*;

  clk_state_s st;
  clk_state_s next_st;
  logic       gate;
  logic       wr;
  logic       btn_event;
  logic       sw_event;
  logic [10:0] target;

  function automatic logic [10:0] bit_target(input logic [7:0] lim,
                                             input logic [1:0] rng);
    logic [7:0] l;
    l = (lim == 8'h00) ? 8'h01 : lim;
    bit_target = {3'h0, l} << (`BR_SHIFT_MAX - rng);
  endfunction

  function automatic synth_frequency_word_word_t synth_frequency_word_word(input logic [7:0] lo,
                                           input logic [4:0] hi,
                                           input logic       mode);
    if (mode)
      synth_frequency_word_word = {hi, lo};
    else
      synth_frequency_word_word = {1'b0, `SYNTH_FREQUENCY_WORD_MODE0_BASE, hi[1:0], lo};
  endfunction

  always_comb begin
    next_st = st;
    next_st.amp_s1 = amplitude_ok_in;
    next_st.amp_s2 = st.amp_s1;
    next_st.sup_s1 = supply_ok_in;
    next_st.sup_s2 = st.sup_s1;
    next_st.sw_s1  = switch_on_input_in;
    next_st.sw_s2  = st.sw_s1;
    next_st.sw_s3  = st.sw_s2;
    next_st.btn_s1 = push_button_wake_pin_n_in;
    next_st.btn_s2 = st.btn_s1;
    next_st.btn_s3 = st.btn_s2;
    sw_event  = st.sw_s2 && !st.sw_s3;
    btn_event = !st.btn_s2 && st.btn_s3;
    // Bus slave: one wait state, write lands on the acknowledged edge
    next_st.ack = wb_cyc_in && wb_stb_in && !st.ack;
    wr  = st.ack && wb_we_in && wb_sel_in[0];
    next_st.rdata = 32'h0000_0000;
    case (wb_adr_in)
      `ADR_CTRL: begin
        next_st.rdata[`CTRL_PERMIT]  = st.permit;
        next_st.rdata[`CTRL_REQUEST] = st.request;
        next_st.rdata[`CTRL_BAND]    = st.band;
        next_st.rdata[`CTRL_RMODE]   = st.rmode;
        next_st.rdata[`CTRL_BR_HI:`CTRL_BR_LO] = st.bit_rate_range_select;
      end
      `ADR_SYNTH_FREQUENCY_WORD_LO: next_st.rdata[7:0] = st.synth_frequency_word_lo;
      `ADR_SYNTH_FREQUENCY_WORD_HI: next_st.rdata[4:0] = st.synth_frequency_word_hi;
      `ADR_LIMIT:   next_st.rdata[7:0] = st.xlim;
      `ADR_STATUS: begin
        next_st.rdata[`ST_OSC_OK]    = st.amp_s2;
        next_st.rdata[`ST_SWITCH_ON] = st.sw_flag;
        next_st.rdata[`ST_BUTTON]    = st.btn_flag;
        next_st.rdata[`ST_CLK_RUN]   = st.run;
        next_st.rdata[`ST_SUPPLY_OK] = st.sup_s2;
      end
      default: next_st.rdata = 32'h0000_0000;
    endcase
    if (!next_st.ack)
      next_st.rdata = st.rdata;
    if (wr) begin
      case (wb_adr_in)
        `ADR_CTRL: begin
          next_st.permit   = wb_dat_in[`CTRL_PERMIT];
          next_st.request  = wb_dat_in[`CTRL_REQUEST];
          next_st.band     = wb_dat_in[`CTRL_BAND];
          next_st.rmode    = wb_dat_in[`CTRL_RMODE];
          next_st.bit_rate_range_select = wb_dat_in[`CTRL_BR_HI:`CTRL_BR_LO];
        end
        `ADR_SYNTH_FREQUENCY_WORD_LO: next_st.synth_frequency_word_lo = wb_dat_in[7:0];
        `ADR_SYNTH_FREQUENCY_WORD_HI: next_st.synth_frequency_word_hi = wb_dat_in[4:0];
        `ADR_LIMIT:   next_st.xlim    = wb_dat_in[7:0];
        `ADR_STATUS: begin
          if (wb_dat_in[`ST_SWITCH_ON])
            next_st.sw_flag = 1'b0;
          if (wb_dat_in[`ST_BUTTON])
            next_st.btn_flag = 1'b0;
        end
        default: ;
      endcase
    end
    // Switch-on flags, set wins over a clear in the same cycle
    if (sw_event)
      next_st.sw_flag = 1'b1;
    if (btn_event)
      next_st.btn_flag = 1'b1;
    next_st.irq = sw_event || btn_event;
    // Wake latch for the controller clock
    if (!st.request)
      next_st.wake = 1'b0;
    else if (bit_check_ok_in || btn_event || st.sw_flag)
      next_st.wake = 1'b1;
    gate = st.permit && st.request && st.wake
           && st.amp_s2 && st.sup_s2;
    // Divide by three of the crystal, equal halves
    if (st.div_cnt == `CLKOUT_LAST) begin
      next_st.div_cnt = 3'h0;
      next_st.run     = gate;
    end else begin
      next_st.div_cnt = st.div_cnt + 3'h1;
    end
    next_st.clk_o = next_st.run && (next_st.div_cnt < `CLKOUT_HALF);
    // Digital clock and bit timing
    next_st.dclk_cnt  = st.dclk_cnt + 5'h01;
    next_st.dclk_tick = (st.dclk_cnt == `DCLK_LAST);
    next_st.bit_tick  = 1'b0;
    target = bit_target(st.xlim, st.bit_rate_range_select);
    if (st.dclk_tick) begin
      if (st.bit_cnt + 11'h001 >= target) begin
        next_st.bit_cnt  = 11'h000;
        next_st.bit_tick = 1'b1;
      end else begin
        next_st.bit_cnt = st.bit_cnt + 11'h001;
      end
    end
    next_st.cap_off = low_power_mode_in;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st          <= '0;
      st.permit   <= `RST_PERMIT;
      st.request  <= `RST_REQUEST;
      st.synth_frequency_word_lo  <= `RST_SYNTH_FREQUENCY_WORD_LO;
      st.synth_frequency_word_hi  <= `RST_SYNTH_FREQUENCY_WORD_HI;
      st.xlim     <= `RST_LIMIT;
      st.btn_s1   <= 1'b1;
      st.btn_s2   <= 1'b1;
      st.btn_s3   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_out             = st.ack;
  assign wb_dat_out             = st.rdata;
  assign mcu_clk_out            = st.clk_o;
  assign oscillator_ok_flag_out = st.amp_s2;
  assign switch_on_flag_out     = st.sw_flag;
  assign switch_on_irq_out      = st.irq;
  assign dclk_tick_out          = st.dclk_tick;
  assign bit_tick_out           = st.bit_tick;
  assign cap_partial_off_out    = st.cap_off;
  assign band_select_bit_out    = st.band;
  assign synth_frequency_word_out =
    synth_frequency_word_word(st.synth_frequency_word_lo, st.synth_frequency_word_hi, st.rmode);

  // Helper: dclk ticks since the last bit tick, valid while config holds
  logic [10:0] h_cnt;
  logic        h_ok;
  logic [10:0] h_tgt;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      h_cnt <= 11'h000;
      h_ok  <= 1'b0;
      h_tgt <= 11'h000;
    end else begin
      h_tgt <= target;
      if (bit_tick_out)
        h_cnt <= 11'h000;
      else if (dclk_tick_out)
        h_cnt <= h_cnt + 11'h001;
      if (target != h_tgt)
        h_ok <= 1'b0;
      else if (bit_tick_out)
        h_ok <= 1'b1;
    end
  end

  a_clk_high_len: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(mcu_clk_out) |=> mcu_clk_out [*2] ##1 !mcu_clk_out)
    else $error("controller clock high phase wrong");
  a_clk_low_len: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $fell(mcu_clk_out) |-> !mcu_clk_out [*3])
    else $error("controller clock low phase truncated");
  a_permit_off: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !st.permit [*4] |-> !mcu_clk_out)
    else $error("clock runs with permit cleared");
  a_request_off: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !st.request [*4] |-> !mcu_clk_out)
    else $error("clock runs with request cleared");
  a_wake_set: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    st.request && bit_check_ok_in |=> st.wake)
    else $error("bit check did not wake clock");
  a_osc_ok: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(oscillator_ok_flag_out) |-> $past(amplitude_ok_in, 2))
    else $error("oscillator ok without amplitude");
  a_clk_start: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(mcu_clk_out) |-> $past(oscillator_ok_flag_out)
      && $past(st.sup_s2) && $past(st.permit))
    else $error("clock started without qualification");
  a_dclk_period: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    dclk_tick_out |=> !dclk_tick_out ##31 dclk_tick_out)
    else $error("digital clock period wrong");
  a_bit_period: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    bit_tick_out && h_ok && target == h_tgt |-> h_cnt == target)
    else $error("bit period wrong");
  a_cap_off: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    low_power_mode_in |=> cap_partial_off_out)
    else $error("loads not reduced in low power");
  a_synth_frequency_word_range: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !st.rmode |-> synth_frequency_word_out >= `SYNTH_FREQUENCY_WORD_MODE0_MIN
      && synth_frequency_word_out <= `SYNTH_FREQUENCY_WORD_MODE0_MAX)
    else $error("frequency word outside mode range");
  a_switch_flag: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    st.sw_s2 && !st.sw_s3 |=> switch_on_flag_out && switch_on_irq_out)
    else $error("switch-on not flagged");
  a_button_wake: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    st.request && !st.btn_s2 && st.btn_s3 |=> st.wake)
    else $error("button did not wake clock");
  a_switch_wake: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    st.request && st.sw_flag |=> st.wake)
    else $error("switch-on flag did not wake clock");
  a_wake_clear: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !st.request |=> !st.wake)
    else $error("wake held with request cleared");
  a_button_flag: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !st.btn_s2 && st.btn_s3 |=> st.btn_flag && switch_on_irq_out)
    else $error("button switch-on not flagged");
  a_irq_cause: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    switch_on_irq_out |-> $past(sw_event) || $past(btn_event))
    else $error("switch-on interrupt without event");
  a_rest_low: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !st.run |-> !mcu_clk_out)
    else $error("controller clock not resting low");
  a_run_start: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(st.run) |-> $past(st.wake) && $past(st.amp_s2)
      && $past(st.sup_s2))
    else $error("clock run started without wake or supply");
  a_permit_stop: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !st.permit && st.div_cnt == `CLKOUT_LAST |=> !st.run)
    else $error("clock run kept with permit cleared");
  a_request_stop: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !st.request && st.div_cnt == `CLKOUT_LAST |=> !st.run)
    else $error("clock run kept with request cleared");
  a_bit_after_dclk: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    bit_tick_out |-> $past(dclk_tick_out))
    else $error("bit tick not on digital clock");
  a_synth_frequency_word_mode1: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    st.rmode |-> synth_frequency_word_out == {st.synth_frequency_word_hi, st.synth_frequency_word_lo})
    else $error("full range frequency word wrong");
  a_cap_on: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !low_power_mode_in |=> !cap_partial_off_out)
    else $error("loads reduced outside low power");
  a_osc_low: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !amplitude_ok_in |-> ##2 !oscillator_ok_flag_out)
    else $error("oscillator ok without amplitude held");
endmodule // xto_clock_gen

// ===== sim/mcu_clk_model.sv
// Controller model that runs from the transceiver clock output
`timescale 1ns/1ps
module mcu_clk_model (
  input  wire logic        clk_in,
  input  wire logic        mcu_clk_in,
  output      logic [7:0]  hi_len_out,
  output      logic [7:0]  lo_len_out,
  output      logic [15:0] edges_out
);
  logic       prev;
  logic [7:0] run;
  initial begin
    prev = 1'b0;
    run = 8'h00;
    hi_len_out = 8'h00;
    lo_len_out = 8'h00;
    edges_out = 16'h0000;
  end
  // Phase lengths in system clocks and count of rising edges
  always @(posedge clk_in) begin
    if (mcu_clk_in !== prev) begin
      if (prev) hi_len_out <= run;
      else lo_len_out <= run;
      if (mcu_clk_in === 1'b1) edges_out <= edges_out + 16'h0001;
      run <= 8'h01;
    end else begin
      run <= run + 8'h01;
    end
    prev <= mcu_clk_in;
  end
endmodule // mcu_clk_model

// ===== sim/xto_clock_gen_tb.sv
// Self-checking bench of the crystal clock divider and gating block
`timescale 1ns/1ps
module xto_clock_gen_tb;
  import xto_clock_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0, amplitude_ok_in = 1'b0, supply_ok_in = 1'b1;
  logic switch_on_input_in = 1'b0, push_button_wake_pin_n_in = 1'b1;
  logic bit_check_ok_in = 1'b0, low_power_mode_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'hF;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
  logic wb_ack_out, mcu_clk_out, oscillator_ok_flag_out, switch_on_flag_out;
  logic switch_on_irq_out, dclk_tick_out, bit_tick_out, cap_partial_off_out;
  logic band_select_bit_out;
  synth_frequency_word_word_t synth_frequency_word_out;
  logic [7:0] hi_len, lo_len;
  logic [15:0] edges, e0;
  int n_errors = 0, samples_checked = 0, cycles = 0, n;
  always #20 clk_in = ~clk_in;
  xto_clock_gen i_dut (.clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .amplitude_ok_in, .supply_ok_in, .switch_on_input_in,
    .push_button_wake_pin_n_in, .bit_check_ok_in, .low_power_mode_in,
    .mcu_clk_out, .oscillator_ok_flag_out, .switch_on_flag_out,
    .switch_on_irq_out, .dclk_tick_out, .bit_tick_out, .cap_partial_off_out,
    .band_select_bit_out, .synth_frequency_word_out);
  mcu_clk_model i_mcu (.clk_in(clk_in), .mcu_clk_in(mcu_clk_out),
    .hi_len_out(hi_len), .lo_len_out(lo_len), .edges_out(edges));
  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_sel_in <= 4'hF;
    wb_adr_in <= a;
    wb_dat_in <= d;
    @(posedge clk_in);
    while (wb_ack_out !== 1'b1) @(posedge clk_in);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic gap(input logic t, output int k);
    k = 0;
    while ((t ? bit_tick_out : dclk_tick_out) !== 1'b1) @(posedge clk_in);
    @(posedge clk_in);
    while ((t ? bit_tick_out : dclk_tick_out) !== 1'b1 && k < 600) begin
      @(posedge clk_in);
      k++;
    end
    k++;
  endtask
  task automatic t_reset_values();
    rd(8'h00, 32'h03, "ctrl");
    rd(8'h04, 32'hFF, "synth_frequency_word_lo");
    rd(8'h08, 32'h0F, "synth_frequency_word_hi");
    rd(8'h0C, 32'h01, "limit");
    rd(8'h14, 32'h00, "unmapped");
    chk("word", 32'd4095, 32'(synth_frequency_word_out));
  endtask
  task automatic t_start();
    bit_check_ok_in <= 1'b1;
    @(posedge clk_in);
    bit_check_ok_in <= 1'b0;
    repeat (30) @(posedge clk_in);
    chk("edges_no_osc", 32'h0, 32'(edges));
    amplitude_ok_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("osc_ok", 32'h1, 32'(oscillator_ok_flag_out));
    repeat (40) @(posedge clk_in);
    chk("high_len", 32'd3, 32'(hi_len));
    chk("low_len", 32'd3, 32'(lo_len));
  endtask
  task automatic t_gating();
    wb(1'b1, 8'h00, 32'h02);
    repeat (12) @(posedge clk_in);
    e0 = edges;
    repeat (30) @(posedge clk_in);
    chk("permit_off", 32'(e0), 32'(edges));
    chk("rest_low", 32'h0, 32'(mcu_clk_out));
    wb(1'b1, 8'h00, 32'h01);
    wb(1'b1, 8'h00, 32'h03);
    e0 = edges;
    repeat (30) @(posedge clk_in);
    chk("request_off", 32'(e0), 32'(edges));
    push_button_wake_pin_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    push_button_wake_pin_n_in <= 1'b1;
    repeat (30) @(posedge clk_in);
    chk("button_wake", 32'h1, 32'(edges > e0 + 16'd3));
  endtask
  task automatic t_switch_on();
    switch_on_input_in <= 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge clk_in);
      if (switch_on_irq_out === 1'b1) n++;
    end
    chk("irq_pulses", 32'd1, 32'(n));
    chk("sw_flag", 32'h1, 32'(switch_on_flag_out));
    wb(1'b0, 8'h10, 32'h0);
    chk("status_sw", 32'h1F, q & 32'h1F);
    wb(1'b1, 8'h10, 32'h2);
    rd(8'h10, 32'h1D, "status_clr");
  endtask
  task automatic t_timing();
    gap(1'b0, n);
    chk("dclk_period", 32'd32, 32'(n));
    wb(1'b1, 8'h0C, 32'h02);
    wb(1'b1, 8'h00, 32'h33);
    gap(1'b1, n);
    gap(1'b1, n);
    chk("bit_period_r3", 32'd64, 32'(n));
    wb(1'b1, 8'h0C, 32'h01);
    wb(1'b1, 8'h00, 32'h03);
    gap(1'b1, n);
    gap(1'b1, n);
    chk("bit_period_r0", 32'd256, 32'(n));
  endtask
  task automatic t_synth_frequency_word();
    wb(1'b1, 8'h04, 32'h34);
    wb(1'b1, 8'h08, 32'h15);
    wb(1'b1, 8'h00, 32'h0F);
    chk("word_m1", 32'h1534, 32'(synth_frequency_word_out));
    chk("band", 32'h1, 32'(band_select_bit_out));
    wb(1'b1, 8'h00, 32'h03);
    chk("word_m0", 32'h0D34, 32'(synth_frequency_word_out));
    chk("band_lo", 32'h0, 32'(band_select_bit_out));
    wb(1'b1, 8'h04, 32'h3C);
    wb(1'b1, 8'h08, 32'h03);
    chk("word_single", 32'd3900, 32'(synth_frequency_word_out));
    low_power_mode_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("cap_off", 32'h1, 32'(cap_partial_off_out));
    low_power_mode_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("cap_on", 32'h0, 32'(cap_partial_off_out));
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset_values();
    t_start();
    t_gating();
    t_switch_on();
    t_timing();
    t_synth_frequency_word();
    stop_test();
  end
endmodule // xto_clock_gen_tb
